// *** design/sirq_pkg.sv ***
// Shared constants and types of the serialized interrupt link.
// Assumes both ends run on the same bus clock mclk at 25 MHz.
package sirq_pkg;

  // Start frame low run, in clocks.
  localparam int START_MIN_CLKS = 4;
  localparam int START_MAX_CLKS = 8;

  // Stop frame low run, in clocks; the length picks the next mode.
  localparam int STOP_QUIET_CLKS = 2;
  localparam int STOP_CONT_CLKS  = 3;

  // Frame layout: slot n (IRQ n) is sampled at clock 3n+2 after the start.
  localparam int FRAME_CLKS = 3;
  localparam int NUM_SLOTS  = 32;
  localparam int POS_W      = 7;
  localparam int SLOT_W     = 5;
  localparam int IRQ_W      = 16;
  localparam logic [POS_W-1:0]  FIRST_POS = 7'h01;
  localparam logic [POS_W-1:0]  LAST_POS  = POS_W'(FRAME_CLKS * NUM_SLOTS + 1);
  localparam logic [SLOT_W-1:0] LAST_SLOT = SLOT_W'(NUM_SLOTS - 1);

  // Interrupt numbers the peripheral may report: 3, 4, 5, 7, 9, 10, 11.
  localparam logic [IRQ_W-1:0] IRQ_MASK = 16'h0eb8;

  // Width of the low-run counters.
  localparam int RUN_W = 4;

  typedef enum logic [1:0] {PH_SAMPLE, PH_RECOVER, PH_TURN} phase_e;

  // True when a slot carries one of the sixteen legacy interrupt numbers.
  function automatic logic slot_is_irq(input logic [SLOT_W-1:0] slot);
    return slot < SLOT_W'(IRQ_W);
  endfunction

endpackage

// *** design/sirq_if.sv ***
// The shared serial interrupt wire between the host and one peripheral.
// The wire has a pull-up: with no enable high it reads as 1.
`timescale 1ns/1ps
interface sirq_if;
  logic dev_o;
  logic dev_oe;
  logic host_o;
  logic host_oe;
  logic line;

  // Wired resolution; a low from either driver wins, as on a real bus.
  assign line = (dev_oe ? dev_o : 1'b1) & (host_oe ? host_o : 1'b1);

  modport device (input line, output dev_o, output dev_oe);
  modport host   (input line, output host_o, output host_oe);
endinterface

// *** design/sirq_slot_counter.sv ***
// Frame counter shared by both ends: tracks clock position, phase and slot.
// Assumes start pulses in the clock right after the start frame's low run.
`timescale 1ns/1ps
module sirq_slot_counter (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        start,
  output logic                             run,
  output sirq_pkg::phase_e                 phase,
  output logic [sirq_pkg::SLOT_W-1:0]      slot,
  output logic                             done,
  output logic                             run_next,
  output sirq_pkg::phase_e                 phase_next,
  output logic [sirq_pkg::SLOT_W-1:0]      slot_next
);
  logic [sirq_pkg::POS_W-1:0] pos_reg;
  logic [sirq_pkg::POS_W-1:0] pos_next;

  assign done = run && (pos_reg == sirq_pkg::LAST_POS);

  always_comb begin
    pos_next   = pos_reg;
    run_next   = run;
    phase_next = phase;
    slot_next  = slot;
    if (start) begin
      // The clock after the start is the start frame's turn-around.
      pos_next   = sirq_pkg::FIRST_POS;
      run_next   = 1'b1;
      phase_next = sirq_pkg::PH_TURN;
      slot_next  = sirq_pkg::LAST_SLOT;
    end else if (done) begin
      run_next = 1'b0;
    end else if (run) begin
      pos_next = pos_reg + 7'h01;
      unique case (phase)
        sirq_pkg::PH_SAMPLE:  phase_next = sirq_pkg::PH_RECOVER;
        sirq_pkg::PH_RECOVER: phase_next = sirq_pkg::PH_TURN;
        sirq_pkg::PH_TURN: begin
          phase_next = sirq_pkg::PH_SAMPLE;
          slot_next  = slot + 5'h01;
        end
        default: phase_next = sirq_pkg::PH_TURN;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pos_reg <= '0;
      run     <= 1'b0;
      phase   <= sirq_pkg::PH_TURN;
      slot    <= '0;
    end else begin
      pos_reg <= pos_next;
      run     <= run_next;
      phase   <= phase_next;
      slot    <= slot_next;
    end
  end
endmodule

// *** design/sirq_device.sv ***
// Peripheral end of the serialized interrupt line.
// Assumes the host end keeps its own framing and that irq_in is synchronous.
//
// Rules of the serialized interrupt link
// - Release the shared line whenever it is idle.
// - Cycle is start, IRQ frames, then stop.
// - Start frame holds the line low 4-8 clocks.
// - Continuous mode: only host begins start frames.
// - Reset puts the peripheral in continuous mode.
// - Quiet mode: peripheral pulses low one clock, releases.
// - Host extends that pulse by 3-7 low clocks.
// - Host ends start low with one high clock.
// - No start frame while a cycle is active.
// - Count frames on every clock after start.
// - Each frame: sample, recovery, turn-around clocks.
// - Sample phase: drive low if interrupt active.
// - Recovery drives high after a low sample.
// - Report only interrupts 3,4,5,7,9,10,11.
// - Slot n sampled 3n+2 clocks after start.
// - Only host ends the cycle, 2-3 low clocks.
// - Stop length two is quiet, three continuous.
`timescale 1ns/1ps
module sirq_device (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic [sirq_pkg::IRQ_W-1:0] irq_in,
  output logic                          mode_continuous,
  output logic                          cycle_active,
  output logic                          change_pending,
  sirq_if.device                        bus
);
  typedef enum logic [1:0] {D_IDLE, D_FRAMES, D_STOP} dev_state_e;

  dev_state_e                      state_reg;
  dev_state_e                      state_next;
  logic [sirq_pkg::RUN_W-1:0]      low_cnt_reg;
  logic [sirq_pkg::RUN_W-1:0]      low_cnt_next;
  logic                            mode_cont_reg;
  logic                            mode_cont_next;
  logic [sirq_pkg::IRQ_W-1:0]      irq_last_reg;
  logic [sirq_pkg::IRQ_W-1:0]      irq_masked;
  logic                            pending_reg;
  logic                            pending_next;
  logic                            drove_reg;
  logic                            drove_next;
  logic                            oe_reg;
  logic                            oe_next;
  logic                            o_reg;
  logic                            o_next;
  logic                            start_seen;
  logic                            pulse_now;
  logic                            cnt_done;
  logic                            cnt_run_next;
  sirq_pkg::phase_e                cnt_phase_next;
  logic [sirq_pkg::SLOT_W-1:0]     cnt_slot_next;

  assign bus.dev_oe      = oe_reg;
  assign bus.dev_o       = o_reg;
  assign mode_continuous = mode_cont_reg;
  assign cycle_active    = (state_reg != D_IDLE);
  assign change_pending  = pending_reg;

  // Interrupts outside the supported set never reach the line.
  assign irq_masked = irq_in & sirq_pkg::IRQ_MASK;

  // A high clock after a long enough low run is clock 0 of the frames.
  // Longer runs than the maximum are still accepted, so a slow host
  // cannot make the peripheral lose a cycle.
  assign start_seen = (state_reg == D_IDLE) && bus.line &&
                      (low_cnt_reg >= sirq_pkg::RUN_W'(sirq_pkg::START_MIN_CLKS));

  // Our own pulse fires only from a fully quiet, released line.
  // With no host answering, the pulse repeats once the line has settled
  // again; a host in quiet mode always takes the low run over.
  assign pulse_now = (state_reg == D_IDLE) && !mode_cont_reg && pending_reg &&
                     bus.line && (low_cnt_reg == '0) && !oe_reg;

  // Only the next-value outputs feed the drive path, which works one clock
  // ahead so that the registered pin lines up with the frame; the present
  // run, phase and slot are left open, and done drives the cycle tracking.
  sirq_slot_counter u_count (
    .mclk       (mclk),
    .rst        (rst),
    .start      (start_seen),
    .run        (),
    .phase      (),
    .slot       (),
    .done       (cnt_done),
    .run_next   (cnt_run_next),
    .phase_next (cnt_phase_next),
    .slot_next  (cnt_slot_next)
  );

  // Length of the current low run on the line, saturating.
  // Saturation keeps a stuck-low line from wrapping into a false short run.
  always_comb begin
    if (bus.line) begin
      low_cnt_next = '0;
    end else if (low_cnt_reg == '1) begin
      low_cnt_next = low_cnt_reg;
    end else begin
      low_cnt_next = low_cnt_reg + 4'h1;
    end
  end

  // Cycle tracking and mode.
  always_comb begin
    state_next     = state_reg;
    mode_cont_next = mode_cont_reg;
    unique case (state_reg)
      D_IDLE: begin
        if (start_seen) begin
          state_next = D_FRAMES;
        end
      end
      D_FRAMES: begin
        // Start detection is off here, so no start can land mid-cycle.
        if (cnt_done) begin
          state_next = D_STOP;
        end
      end
      D_STOP: begin
        if (bus.line && (low_cnt_reg != '0)) begin
          state_next = D_IDLE;
          if (low_cnt_reg == sirq_pkg::RUN_W'(sirq_pkg::STOP_QUIET_CLKS)) begin
            mode_cont_next = 1'b0;
          end else if (low_cnt_reg == sirq_pkg::RUN_W'(sirq_pkg::STOP_CONT_CLKS)) begin
            mode_cont_next = 1'b1;
          end
        end
      end
      default: state_next = D_IDLE;
    endcase
  end

  // A change raised in the same clock as a start still survives.
  always_comb begin
    pending_next = pending_reg;
    if (start_seen) begin
      pending_next = 1'b0;
    end
    if (irq_masked != irq_last_reg) begin
      pending_next = 1'b1;
    end
  end

  // Line drive, registered so that the pin never glitches.
  // Everything here is computed for the next clock.
  always_comb begin
    oe_next    = 1'b0;
    o_next     = 1'b1;
    drove_next = drove_reg;
    if (pulse_now) begin
      // One low clock only; the host takes over the low run after it.
      oe_next = 1'b1;
      o_next  = 1'b0;
    end else if (cnt_run_next) begin
      unique case (cnt_phase_next)
        sirq_pkg::PH_SAMPLE: begin
          drove_next = sirq_pkg::slot_is_irq(cnt_slot_next) &&
                       irq_masked[cnt_slot_next[3:0]];
          if (drove_next) begin
            oe_next = 1'b1;
            o_next  = 1'b0;
          end
        end
        sirq_pkg::PH_RECOVER: begin
          // Drive high only after our own low, so the wire recovers fast.
          if (drove_reg) begin
            oe_next = 1'b1;
            o_next  = 1'b1;
          end
          drove_next = 1'b0;
        end
        sirq_pkg::PH_TURN: begin
          drove_next = 1'b0;
        end
        default: drove_next = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg     <= D_IDLE;
      low_cnt_reg   <= '0;
      mode_cont_reg <= 1'b1;
      irq_last_reg  <= '0;
      pending_reg   <= 1'b0;
      drove_reg     <= 1'b0;
      oe_reg        <= 1'b0;
      o_reg         <= 1'b1;
    end else begin
      state_reg     <= state_next;
      low_cnt_reg   <= low_cnt_next;
      mode_cont_reg <= mode_cont_next;
      irq_last_reg  <= irq_masked;
      pending_reg   <= pending_next;
      drove_reg     <= drove_next;
      oe_reg        <= oe_next;
      o_reg         <= o_next;
    end
  end

endmodule

// *** design/sirq_host.sv ***
// Host end of the serialized interrupt line: frames cycles, samples slots.
// Assumes a single peripheral model on the wire and synchronous user inputs.
`timescale 1ns/1ps
module sirq_host #(
  parameter int START_LOW_CLKS = sirq_pkg::START_MIN_CLKS
) (
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire logic                         start_req,
  input  wire logic                         next_quiet,
  output logic [sirq_pkg::IRQ_W-1:0]        irq_state,
  output logic                              mode_continuous,
  output logic                              busy,
  output logic                              cycle_done,
  sirq_if.host                              bus
);
  typedef enum logic [2:0] {
    H_IDLE, H_START_LOW, H_START_HIGH, H_FRAMES, H_STOP_LOW, H_STOP_HIGH
  } host_state_e;

  host_state_e                   state_reg;
  host_state_e                   state_next;
  logic [sirq_pkg::RUN_W-1:0]    cnt_reg;
  logic [sirq_pkg::RUN_W-1:0]    cnt_next;
  logic                          mode_cont_reg;
  logic                          mode_cont_next;
  logic [sirq_pkg::IRQ_W-1:0]    irq_reg;
  logic [sirq_pkg::IRQ_W-1:0]    irq_next;
  logic                          oe_reg;
  logic                          o_reg;
  logic                          oe_next;
  logic                          o_next;
  logic                          cnt_run;
  logic                          cnt_done;
  sirq_pkg::phase_e              cnt_phase;
  logic [sirq_pkg::SLOT_W-1:0]   cnt_slot;

  assign bus.host_oe      = oe_reg;
  assign bus.host_o       = o_reg;
  assign irq_state        = irq_reg;
  assign mode_continuous  = mode_cont_reg;
  assign busy             = (state_reg != H_IDLE);
  assign cycle_done       = (state_reg == H_STOP_HIGH);

  sirq_slot_counter u_count (
    .mclk       (mclk),
    .rst        (rst),
    .start      (state_reg == H_START_HIGH),
    .run        (cnt_run),
    .phase      (cnt_phase),
    .slot       (cnt_slot),
    .done       (cnt_done),
    .run_next   (),
    .phase_next (),
    .slot_next  ()
  );

  always_comb begin
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    mode_cont_next = mode_cont_reg;
    irq_next       = irq_reg;
    unique case (state_reg)
      H_IDLE: begin
        if (start_req) begin
          state_next = H_START_LOW;
          cnt_next   = sirq_pkg::RUN_W'(START_LOW_CLKS - 1);
        end else if (!mode_cont_reg && !bus.line && !oe_reg) begin
          // The peripheral's clock counts toward the start run.
          state_next = H_START_LOW;
          cnt_next   = sirq_pkg::RUN_W'(START_LOW_CLKS - 2);
        end
      end
      H_START_LOW: begin
        if (cnt_reg == '0) begin
          state_next = H_START_HIGH;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      H_START_HIGH: state_next = H_FRAMES;
      H_FRAMES: begin
        if (cnt_run && (cnt_phase == sirq_pkg::PH_SAMPLE) &&
            sirq_pkg::slot_is_irq(cnt_slot)) begin
          irq_next[cnt_slot[3:0]] = !bus.line;
        end
        if (cnt_done) begin
          state_next     = H_STOP_LOW;
          mode_cont_next = !next_quiet;
          cnt_next       = next_quiet ?
                           sirq_pkg::RUN_W'(sirq_pkg::STOP_QUIET_CLKS - 1) :
                           sirq_pkg::RUN_W'(sirq_pkg::STOP_CONT_CLKS - 1);
        end
      end
      H_STOP_LOW: begin
        if (cnt_reg == '0) begin
          state_next = H_STOP_HIGH;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      H_STOP_HIGH: state_next = H_IDLE;
      default:     state_next = H_IDLE;
    endcase
    // The pin follows the state being entered, so it changes on the same edge.
    oe_next = (state_next == H_START_LOW) || (state_next == H_START_HIGH) ||
              (state_next == H_STOP_LOW)  || (state_next == H_STOP_HIGH);
    o_next  = (state_next == H_START_HIGH) || (state_next == H_STOP_HIGH);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg     <= H_IDLE;
      cnt_reg       <= '0;
      mode_cont_reg <= 1'b1;
      irq_reg       <= '0;
      oe_reg        <= 1'b0;
      o_reg         <= 1'b1;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      mode_cont_reg <= mode_cont_next;
      irq_reg       <= irq_next;
      oe_reg        <= oe_next;
      o_reg         <= o_next;
    end
  end
endmodule

// *** testbench/sirq_properties.sv ***
// Concurrent checks on the serial interrupt wire between host and peripheral ends.
// Assumes it sees the wire signals of one sirq_if, clocked by mclk, sync reset rst.
`timescale 1ns/1ps
module sirq_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic host_o,
  input wire logic host_oe,
  input wire logic line
);
  logic [3:0]  low_run_reg;
  logic [3:0]  low_run_next;
  logic        in_cycle_reg;
  logic        in_cycle_next;
  logic [6:0]  pos_reg;
  logic [6:0]  pos_next;
  logic        cont_reg;
  logic        cont_next;
  logic        start_clk;
  logic        stop_clk;
  logic [31:0] slot_mask;

  // The checker keeps its own framing from the wire alone, so a design that
  // miscounts cannot hide behind its own notion of clock position.
  assign slot_mask = {16'h0000, sirq_pkg::IRQ_MASK};
  assign start_clk = line && !in_cycle_reg && (low_run_reg >= 4'h4);
  assign stop_clk  = line && in_cycle_reg && (pos_reg >= 7'h62) &&
                     (low_run_reg inside {4'h2, 4'h3});

  always_comb begin
    low_run_next  = line ? 4'h0 : ((low_run_reg == 4'hf) ? low_run_reg : low_run_reg + 4'h1);
    in_cycle_next = in_cycle_reg;
    pos_next      = (in_cycle_reg && pos_reg != 7'h7f) ? pos_reg + 7'h01 : pos_reg;
    cont_next     = cont_reg;
    if (start_clk) begin
      in_cycle_next = 1'b1;
      pos_next      = 7'h01;
    end
    if (stop_clk) begin
      in_cycle_next = 1'b0;
      cont_next     = (low_run_reg == 4'h3);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      low_run_reg  <= 4'h0;
      in_cycle_reg <= 1'b0;
      pos_reg      <= 7'h00;
      cont_reg     <= 1'b1;
    end else begin
      low_run_reg  <= low_run_next;
      in_cycle_reg <= in_cycle_next;
      pos_reg      <= pos_next;
      cont_reg     <= cont_next;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence stop_two_s;
    (host_oe && !host_o) [*2] ##1 (host_oe && host_o);
  endsequence
  sequence stop_three_s;
    (host_oe && !host_o) [*3] ##1 (host_oe && host_o);
  endsequence
  sequence dev_low_s;
    dev_oe && !dev_o;
  endsequence

  start_low_bound_a: assert property (low_run_reg <= 4'h8)
    else $error("line held low longer than a start frame");
  start_high_a: assert property (start_clk |-> host_oe && host_o ##1 !host_oe)
    else $error("host did not drive one high clock after the start low run");
  busy_no_start_a: assert property (in_cycle_reg |-> low_run_reg <= 4'h3)
    else $error("start frame seen inside an active cycle");
  idle_release_a: assert property (dev_oe && !in_cycle_reg |-> !dev_o ##1 !dev_oe)
    else $error("peripheral held the idle line beyond a one clock low pulse");
  quiet_takeover_a: assert property (dev_low_s and !in_cycle_reg |=> host_oe && !host_o)
    else $error("host did not extend the peripheral start pulse");
  cont_no_pulse_a: assert property (cont_reg && $past(cont_reg) && !in_cycle_reg |-> !dev_oe)
    else $error("peripheral drove the line while idle in continuous mode");
  slot_place_a: assert property (dev_low_s and in_cycle_reg |->
    (pos_reg % 7'h03 == 7'h02) && (pos_reg <= 7'h5f) && slot_mask[(pos_reg - 7'h02) / 7'h03])
    else $error("peripheral sample low outside a reported slot");
  recover_high_a: assert property (dev_low_s and in_cycle_reg |=> dev_oe && dev_o ##1 !dev_oe)
    else $error("recovery high or turn-around release missing");
  sample_first_a: assert property ($rose(dev_oe) |-> !dev_o)
    else $error("peripheral began a drive with a high level");
  stop_frame_a: assert property (in_cycle_reg && pos_reg == 7'h62 |-> stop_two_s or stop_three_s)
    else $error("stop frame not two or three low clocks then high");
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench: host and peripheral ends joined on one wire, plus a lone
// peripheral on a second wire whose host side the bench drives by hand.
`timescale 1ns/1ps
module testbench;
  logic                          mclk;
  logic                          rst;
  logic                          start_req;
  logic                          next_quiet;
  logic                          cur_quiet;
  logic [sirq_pkg::IRQ_W-1:0]    irq_in;
  logic [sirq_pkg::IRQ_W-1:0]    irq_in_2;
  logic [sirq_pkg::IRQ_W-1:0]    new_irq;
  logic [sirq_pkg::IRQ_W-1:0]    irq_state;
  logic [sirq_pkg::IRQ_W-1:0]    exp_q[$];
  logic                          dev_mode;
  logic                          dev_active;
  logic                          dev_pending;
  logic                          host_mode;
  logic                          host_busy;
  logic                          cycle_done;
  logic                          dev2_mode;
  logic                          dev2_active;
  logic [31:0]                   seed;
  int                            error_cnt;
  int                            compares;
  int                            n;

  sirq_if bus_if ();
  sirq_if rogue_if ();

  sirq_device u_sirq_device (.mclk(mclk), .rst(rst), .irq_in(irq_in), .mode_continuous(dev_mode),
    .cycle_active(dev_active), .change_pending(dev_pending), .bus(bus_if));
  sirq_host #(.START_LOW_CLKS(5)) u_sirq_host (.mclk(mclk), .rst(rst), .start_req(start_req),
    .next_quiet(next_quiet), .irq_state(irq_state), .mode_continuous(host_mode),
    .busy(host_busy), .cycle_done(cycle_done), .bus(bus_if));
  sirq_device u_sirq_device_2 (.mclk(mclk), .rst(rst), .irq_in(irq_in_2),
    .mode_continuous(dev2_mode), .cycle_active(dev2_active), .change_pending(), .bus(rogue_if));
  sirq_properties u_sirq_properties (.mclk(mclk), .rst(rst), .dev_o(bus_if.dev_o),
    .dev_oe(bus_if.dev_oe), .host_o(bus_if.host_o), .host_oe(bus_if.host_oe), .line(bus_if.line));

  always #20 mclk = ~mclk;

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk_bit(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_irq(input logic [sirq_pkg::IRQ_W-1:0] exp, input logic [sirq_pkg::IRQ_W-1:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] irq_state expected %h seen %h", exp, got);
    end
  endtask

  task automatic end_sim;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Bench stands in for a host: n low clocks, one high clock, then release.
  task automatic rogue_low(input int cnt);
    rogue_if.host_oe = 1'b1;
    rogue_if.host_o  = 1'b0;
    repeat (cnt) @(negedge mclk);
    rogue_if.host_o = 1'b1;
    @(negedge mclk);
    rogue_if.host_oe = 1'b0;
  endtask

  task automatic wait_done;
    n = 0;
    while (cycle_done !== 1'b1 && n < 300) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 300) begin
      error_cnt++;
      $display("[ERR] cycle_done expected 1 seen timeout");
    end
    @(negedge mclk);
  endtask

  // Sampled on the falling edge, where the stop high clock's outputs are settled.
  always @(negedge mclk) begin
    if (!rst && cycle_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        compares++;
        error_cnt++;
        $display("[ERR] cycle_done expected 0 seen 1");
      end else
        chk_irq(exp_q.pop_front(), irq_state);
    end
  end

  initial begin
    #(40 * 6000);
    error_cnt++;
    $display("[ERR] watchdog expected finish seen timeout");
    end_sim();
  end

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    start_req = 1'b0;
    next_quiet = 1'b0;
    cur_quiet = 1'b0;
    irq_in = 16'h0000;
    irq_in_2 = 16'h0000;
    rogue_if.host_o = 1'b1;
    rogue_if.host_oe = 1'b0;
    seed = 32'h4a9bf070;
    error_cnt = 0;
    compares = 0;
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    chk_bit("dev_mode", 1'b1, dev_mode);
    chk_bit("host_mode", 1'b1, host_mode);
    rogue_low(3);
    repeat (2) @(negedge mclk);
    chk_bit("dev2_active", 1'b0, dev2_active);
    rogue_low(4);
    repeat (2) @(negedge mclk);
    chk_bit("dev2_active", 1'b1, dev2_active);
    repeat (95) @(negedge mclk);
    rogue_low(2);
    repeat (3) @(negedge mclk);
    chk_bit("dev2_mode", 1'b0, dev2_mode);
    chk_bit("dev2_active", 1'b0, dev2_active);
    irq_in_2 = 16'h0010;
    n = 0;
    while (rogue_if.dev_oe !== 1'b1 && n < 6) begin
      @(negedge mclk);
      n++;
    end
    chk_bit("dev2_pulse_low", 1'b0, rogue_if.dev_o);
    @(negedge mclk);
    chk_bit("dev2_released", 1'b0, rogue_if.dev_oe);
    for (int i = 0; i < 10; i++) begin
      seed = xorshift(seed);
      next_quiet = i[0];
      new_irq = seed[15:0];
      if (cur_quiet) begin
        if (((new_irq ^ irq_in) & sirq_pkg::IRQ_MASK) == 16'h0000)
          new_irq = new_irq ^ 16'h0008;
      end else
        start_req = 1'b1;
      irq_in = new_irq;
      exp_q.push_back(new_irq & sirq_pkg::IRQ_MASK);
      @(negedge mclk);
      start_req = 1'b0;
      repeat (20) @(negedge mclk);
      start_req = 1'b1;
      @(negedge mclk);
      start_req = 1'b0;
      wait_done();
      repeat (3) @(negedge mclk);
      cur_quiet = next_quiet;
      chk_bit("dev_mode", !cur_quiet, dev_mode);
      chk_bit("host_mode", !cur_quiet, host_mode);
      chk_bit("dev_active", 1'b0, dev_active);
      chk_bit("dev_pending", 1'b0, dev_pending);
    end
    irq_in = irq_in ^ 16'h0001;
    repeat (30) @(negedge mclk);
    chk_bit("host_busy", 1'b0, host_busy);
    chk_bit("dev_pending", 1'b0, dev_pending);
    end_sim();
  end
endmodule
